// file: dv/mesf_event_model.sv
// Purpose: Model of the event sources that feed the status bank
// Assumes: Commands are one-cycle pulses from the bench, driven on clk
// Notes:   Outputs are registered, so each command lands one cycle later
`timescale 1ns/100ps
module mesf_event_model
(
   input  wire logic               clk,       // System clock
   input  wire logic               rstn,      // Sync reset, active low
   input  wire logic [14:0]        tgl_half,  // Toggle accumulator bits
   input  wire logic [14:0]        tgl_sign,  // Toggle power signs
   input  wire logic [4:0]         pulse_cmd, // Compute, line, outputs 2..0
   output mesf_pkg::mesf_half_t    half_bit,  // Accumulator bit 30
   output mesf_pkg::mesf_sign_in_t sign,      // Power signs
   output logic [2:0]              pulse_lvl, // Frequency output levels
   output logic                    line_done, // Integration end
   output logic                    comp_done  // Compute cycle end
);
   import mesf_pkg::*;
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         half_bit  <= '0;
         sign      <= '0;
         pulse_lvl <= 3'h7;
         line_done <= 1'b0;
         comp_done <= 1'b0;
      end
      else
      begin
         half_bit  <= half_bit ^ tgl_half;
         sign      <= sign ^ tgl_sign;
         // Outputs idle high; a pulse is one low cycle
         pulse_lvl <= ~pulse_cmd[2:0];
         line_done <= pulse_cmd[3];
         comp_done <= pulse_cmd[4];
      end
   end
endmodule // mesf_event_model

// file: dv/tb_meter_event_status_flags.sv
// Purpose: Self-checking bench for the meter event status bank
// Assumes: Event sources come from mesf_event_model
// Notes:   Each scenario clears the flags it raised before it returns
`timescale 1ns/100ps
module tb_meter_event_status_flags;
   import mesf_pkg::*;
   logic                    clk, rstn, ce, irq, line_d, comp_d;
   mesf_bus_req_t           bus_req;
   logic [DATA_W-1:0]       rdata;
   mesf_half_t              half_bit;
   mesf_sign_in_t           sgn, sm;
   logic [2:0]              pulse_lvl;
   logic [MODE_W-1:0]       measurement_mode_reg, md;
   logic [PULSE_MODE_W-1:0] pmode;
   logic [HALF_CYC_W-1:0]   hcc;
   logic [14:0]             tgl_half, tgl_sign;
   logic [4:0]              pulse_cmd;
   logic [FLAG_W-1:0]       msk;
   int                      mismatches, comparisons;

   mesf_status_bank dut (.clk(clk), .rstn(rstn), .ce(ce), .bus_req(bus_req), .rdata(rdata),
      .irq(irq), .half_bit(half_bit), .power_sign_in(sgn), .pulse_out_level(pulse_lvl),
      .line_cycle_done(line_d), .compute_done(comp_d), .measurement_mode(measurement_mode_reg),
      .pulse_output_mode(pmode), .half_cycle_count(hcc));
   mesf_event_model src (.clk(clk), .rstn(rstn), .tgl_half(tgl_half), .tgl_sign(tgl_sign),
      .pulse_cmd(pulse_cmd), .half_bit(half_bit), .sign(sgn), .pulse_lvl(pulse_lvl),
      .line_done(line_d), .comp_done(comp_d));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_req <= '{addr:a, wdata:d, wr:1'b1, rd:1'b0};
      if (a == MASK_ADDR) msk = d[FLAG_W-1:0];
      if (a == MODE_ADDR) md = d[MODE_W-1:0];
      @(posedge clk);
      bus_req.wr <= 1'b0;
      // Registers written at this edge settle after it; callers may check them at once
      #1;
   endtask

   // Read data stand for one cycle only, so they are sampled just after the edge
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      @(posedge clk);
      bus_req <= '{addr:a, wdata:32'h0, wr:1'b0, rd:1'b1};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1 chk(rdata, e);
   endtask

   function automatic logic [31:0] esign();
      return {23'h0, sm.sum[2], sm.sum[1], md[1] ? sm.rea_fund : sm.rea_tot,
              sm.sum[0], md[0] ? sm.act_fund : sm.act_tot};
   endfunction

   task automatic fire(input logic [14:0] th, input logic [14:0] ts, input logic [4:0] pc);
      @(posedge clk);
      tgl_half <= th;
      tgl_sign <= ts;
      pulse_cmd <= pc;
      sm = sm ^ ts;
      @(posedge clk);
      tgl_half <= '0;
      tgl_sign <= '0;
      pulse_cmd <= '0;
      repeat (3) @(posedge clk);
   endtask

   task automatic ev(input logic [14:0] th, input logic [14:0] ts, input logic [4:0] pc,
                     input logic [31:0] e);
      fire(th, ts, pc);
      chk(irq, |(e[FLAG_W-1:0] & msk));
      rd(STATUS_ADDR, e);
      rd(SIGN_ADDR, esign());
      wr(STATUS_ADDR, 32'hFFFF_FFFF);
      rd(STATUS_ADDR, 32'h0);
      chk(irq, 1'b0);
   endtask

   task automatic t_reset();
      rd(STATUS_ADDR, 32'h0);
      rd(MASK_ADDR, 32'h0);
      rd(MODE_ADDR, 32'h0);
      rd(PULSE_MODE_ADDR, 32'h0);
      rd(HALF_CYC_ADDR, 32'h0);
      rd(SIGN_ADDR, 32'h0);
      rd(16'h1234, 32'h0);
      chk(irq, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_half();
      for (int i = 0; i < 5; i++)
         ev(15'h1 << (i * 3 + i % 3), 15'h0, 5'h0, 32'h1 << i);
      $display("test half_full done");
   endtask

   task automatic t_sign();
      ev(15'h0, 15'h0007, 5'h0, 32'h0000_01C0);
      ev(15'h0, 15'h0038, 5'h0, 32'h0);
      wr(MODE_ADDR, 32'h1);
      ev(15'h0, 15'h0, 5'h0, 32'h0);
      ev(15'h0, 15'h0038, 5'h0, 32'h0000_01C0);
      ev(15'h0, 15'h01C0, 5'h0, 32'h0000_1C00);
      ev(15'h0, 15'h0E00, 5'h0, 32'h0);
      wr(MODE_ADDR, 32'h3);
      chk(measurement_mode_reg, 2'h3);
      ev(15'h0, 15'h0E00, 5'h0, 32'h0000_1C00);
      ev(15'h0, 15'h1000, 5'h0, 32'h0000_0200);
      ev(15'h0, 15'h2000, 5'h0, 32'h0000_2000);
      ev(15'h0, 15'h4000, 5'h0, 32'h0004_0000);
      $display("test sign_flip done");
   endtask

   task automatic t_pulse();
      wr(PULSE_MODE_ADDR, 32'hFFFF_FFFF);
      rd(PULSE_MODE_ADDR, 32'h0000_0FFF);
      for (int i = 0; i < 3; i++)
         ev(15'h0, 15'h0, 5'h1 << i, 32'h1 << (14 + i));
      wr(PULSE_MODE_ADDR, 32'h0000_01D1);
      rd(PULSE_MODE_ADDR, 32'h0000_01D1);
      chk(pmode, 12'h1D1);
      $display("test pulse done");
   endtask

   task automatic t_irq();
      wr(MASK_ADDR, 32'hFFFF_FFFF);
      rd(MASK_ADDR, 32'h0007_FFFF);
      wr(MASK_ADDR, 32'h0002_0000);
      ev(15'h0, 15'h0, 5'h10, 32'h0002_0000);
      ev(15'h0, 15'h0, 5'h08, 32'h0000_0020);
      $display("test line_compute_irq done");
   endtask

   task automatic t_sticky();
      fire(15'h0001, 15'h0, 5'h08);
      repeat (20) @(posedge clk);
      rd(STATUS_ADDR, 32'h0000_0021);
      wr(STATUS_ADDR, 32'h0000_0001);
      rd(STATUS_ADDR, 32'h0000_0020);
      wr(STATUS_ADDR, 32'h0);
      rd(STATUS_ADDR, 32'h0000_0020);
      wr(STATUS_ADDR, 32'hFFFF_FFFF);
      rd(STATUS_ADDR, 32'h0);
      $display("test sticky done");
   endtask

   task automatic t_regs();
      wr(HALF_CYC_ADDR, 32'hFFFF_ABCD);
      rd(HALF_CYC_ADDR, 32'h0000_ABCD);
      chk(hcc, 16'hABCD);
      wr(SIGN_ADDR, 32'hFFFF_FFFF);
      rd(SIGN_ADDR, esign());
      // Requests and events while the enable is low must be lost
      @(posedge clk);
      ce <= 1'b0;
      wr(HALF_CYC_ADDR, 32'h0);
      fire(15'h0002, 15'h0, 5'h0);
      fire(15'h0002, 15'h0, 5'h0);
      @(posedge clk);
      ce <= 1'b1;
      repeat (3) @(posedge clk);
      rd(STATUS_ADDR, 32'h0);
      rd(HALF_CYC_ADDR, 32'h0000_ABCD);
      $display("test regs_enable done");
   endtask

   task automatic give_verdict();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial
   begin
      repeat (100000) @(posedge clk);
      mismatches++;
      give_verdict();
   end

   initial
   begin
      rstn = 1'b0;
      ce = 1'b1;
      bus_req = '0;
      tgl_half = '0;
      tgl_sign = '0;
      pulse_cmd = '0;
      sm = '0;
      md = '0;
      msk = '0;
      mismatches = 0;
      comparisons = 0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      // Change detectors need one sample before they can flag
      repeat (4) @(posedge clk);
      t_reset();
      t_half();
      t_sign();
      t_pulse();
      t_irq();
      t_sticky();
      t_regs();
      give_verdict();
   end
endmodule // tb_meter_event_status_flags

// file: include/mesf_pkg.sv
// Purpose: Constants, field layout and carrier types for the meter event status bank
// Assumes: 16-bit register addresses, 32-bit register data, 125 MHz clock
// Notes:   Summary of operation follows
// Summary of operation
// - Total active accumulator bit 30 change sets bit 0
// - Fundamental active bit 30 change sets bit 1
// - Total reactive bit 30 change sets bit 2
// - Fundamental reactive bit 30 change sets bit 3
// - Apparent accumulator bit 30 change sets bit 4
// - Line-cycle integration end sets bit 5
// - Phase active sign flips set bits 6-8
// - First pulse path sum sign flip sets 9
// - Phase reactive sign flips set bits 10-12
// - Second pulse path sum flip sets 13
// - Third pulse path sum flip sets 18
// - First frequency output pulse sets bit 14
// - Second frequency output pulse sets bit 15
// - Third frequency output pulse sets bit 16
// - Three-bit source selects per frequency output
// - Compute cycle completion sets bit 17
// - Bits 31 to 19 read zero

package mesf_pkg;

   localparam int ADDR_W           = 16;
   localparam int DATA_W           = 32;
   localparam int FLAG_W           = 19;
   localparam int MODE_W           = 2;
   localparam int PULSE_MODE_W     = 12;
   localparam int SIGN_W           = 9;
   localparam int HALF_CYC_W       = 16;
   localparam int SRC_W            = 3;

   localparam logic [ADDR_W-1:0] STATUS_ADDR     = 16'hE502;
   localparam logic [ADDR_W-1:0] MODE_ADDR       = 16'hE600;
   localparam logic [ADDR_W-1:0] PULSE_MODE_ADDR = 16'hE601;
   localparam logic [ADDR_W-1:0] SIGN_ADDR       = 16'hE602;
   localparam logic [ADDR_W-1:0] MASK_ADDR       = 16'hE603;
   localparam logic [ADDR_W-1:0] HALF_CYC_ADDR   = 16'hE604;

   // Status bit positions
   localparam int TOT_ACT_HF_BIT   = 0;
   localparam int FUND_ACT_HF_BIT  = 1;
   localparam int TOT_REA_HF_BIT   = 2;
   localparam int FUND_REA_HF_BIT  = 3;
   localparam int APP_HF_BIT       = 4;
   localparam int LINE_CYC_BIT     = 5;
   localparam int ACT_FLIP_LSB     = 6;
   localparam int SUM_ONE_FLIP_BIT = 9;
   localparam int REA_FLIP_LSB     = 10;
   localparam int SUM_TWO_FLIP_BIT = 13;
   localparam int PULSE_FLAG_LSB   = 14;
   localparam int COMPUTE_BIT      = 17;
   localparam int SUM_THR_FLIP_BIT = 18;

   // Measurement mode fields: 0 selects total power, 1 fundamental
   localparam int ACT_SEL_BIT      = 0;
   localparam int REA_SEL_BIT      = 1;

   // Pulse output mode fields
   localparam int SRC_ONE_LSB      = 0;
   localparam int SRC_TWO_LSB      = 3;
   localparam int SRC_THREE_LSB    = 6;
   localparam int DIS_ONE_BIT      = 9;
   localparam int DIS_TWO_BIT      = 10;
   localparam int DIS_THREE_BIT    = 11;

   // Power sign register fields
   localparam int ACT_SIGN_LSB     = 0;
   localparam int SUM_ONE_SIGN_BIT = 3;
   localparam int REA_SIGN_LSB     = 4;
   localparam int SUM_TWO_SIGN_BIT = 7;
   localparam int SUM_THR_SIGN_BIT = 8;

   localparam logic [FLAG_W-1:0]       STATUS_RST     = 19'h00000;
   localparam logic [FLAG_W-1:0]       MASK_RST       = 19'h00000;
   localparam logic [MODE_W-1:0]       MODE_RST       = 2'h0;
   localparam logic [PULSE_MODE_W-1:0] PULSE_MODE_RST = 12'h000;
   localparam logic [HALF_CYC_W-1:0]   HALF_CYC_RST   = 16'h0000;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } mesf_bus_req_t;

   // Bit 30 of each accumulator, phases C B A from left
   typedef struct packed {
      logic [2:0] app;
      logic [2:0] fund_rea;
      logic [2:0] tot_rea;
      logic [2:0] fund_act;
      logic [2:0] tot_act;
   } mesf_half_t;

   // Sign of each power, 1 = negative
   typedef struct packed {
      logic [2:0] sum;
      logic [2:0] rea_fund;
      logic [2:0] rea_tot;
      logic [2:0] act_fund;
      logic [2:0] act_tot;
   } mesf_sign_in_t;

endpackage

// file: rtl/mesf_change_det.sv
// Purpose: Registers a vector and flags every bit that changed
// Assumes: Input comes from logic on the same clock
// Notes:   No change is reported until one value has been sampled
`timescale 1ns/100ps
module mesf_change_det #(
   parameter int W = 1
)
(
   input  wire logic         clk,   // System clock
   input  wire logic         rstn,  // Synchronous reset, active low
   input  wire logic         ce,    // Clock enable
   input  wire logic [W-1:0] din,   // Watched vector
   output logic      [W-1:0] dq,    // Last sampled value
   output logic      [W-1:0] chg    // Bits that differ from last sample
);
   logic [W-1:0] dq_reg;
   logic [W-1:0] dq_next;
   logic         primed_reg;
   logic         primed_next;

   always_comb
   begin
      dq_next     = dq_reg;
      primed_next = primed_reg;
      if (ce)
      begin
         dq_next     = din;
         primed_next = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         dq_reg     <= '0;
         primed_reg <= 1'b0;
      end
      else
      begin
         dq_reg     <= dq_next;
         primed_reg <= primed_next;
      end
   end

   // Gated by ce so a frozen cycle cannot set a flag
   assign chg = (ce && primed_reg) ? (din ^ dq_reg) : '0;
   assign dq  = dq_reg;

endmodule // mesf_change_det

// file: rtl/mesf_status_bank.sv
// Purpose: Event status register with mask, interrupt and mode registers
// Assumes: Event sources run on clk; register port answers one cycle later
// Notes:   Flags are sticky and cleared by writing ones
`timescale 1ns/100ps
module mesf_status_bank
(
   input  wire logic                                   clk,             // 125 MHz clock
   input  wire logic                                   rstn,            // Sync reset, low
   input  wire logic                                   ce,              // Clock enable
   input  wire mesf_pkg::mesf_bus_req_t                bus_req,         // Register request
   output logic [mesf_pkg::DATA_W-1:0]                 rdata,           // Read data
   output logic                                        irq,             // Interrupt level
   input  wire mesf_pkg::mesf_half_t                   half_bit,        // Accumulator bit 30
   input  wire mesf_pkg::mesf_sign_in_t                power_sign_in,   // Power signs
   input  wire logic [2:0]                             pulse_out_level, // Frequency outputs
   input  wire logic                                   line_cycle_done, // Integration end
   input  wire logic                                   compute_done,    // Compute cycle end
   output logic [mesf_pkg::MODE_W-1:0]                 measurement_mode,  // Sign sources
   output logic [mesf_pkg::PULSE_MODE_W-1:0]           pulse_output_mode, // Selects, disables
   output logic [mesf_pkg::HALF_CYC_W-1:0]             half_cycle_count   // Half cycle count
);
   import mesf_pkg::*;

   logic [FLAG_W-1:0]       status_reg;
   logic [FLAG_W-1:0]       status_next;
   logic [FLAG_W-1:0]       mask_reg;
   logic [FLAG_W-1:0]       mask_next;
   logic [MODE_W-1:0]       mode_reg;
   logic [MODE_W-1:0]       mode_next;
   logic [PULSE_MODE_W-1:0] pulse_mode_reg;
   logic [PULSE_MODE_W-1:0] pulse_mode_next;
   logic [HALF_CYC_W-1:0]   half_cyc_reg;
   logic [HALF_CYC_W-1:0]   half_cyc_next;
   logic [DATA_W-1:0]       rdata_reg;
   logic [DATA_W-1:0]       rdata_next;
   logic                    irq_reg;
   logic                    irq_next;

   logic [FLAG_W-1:0]       set_vec;
   logic [FLAG_W-1:0]       wr_clr;
   logic [14:0]             hf_vec;
   logic [14:0]             hf_chg;
   logic [SIGN_W-1:0]       sel_sign;
   logic [SIGN_W-1:0]       power_sign_reg;
   logic [SIGN_W-1:0]       sign_chg;
   logic [2:0]              pulse_chg;
   logic [2:0]              pulse_fall;

   // Picks total or fundamental sign for three phases
   function automatic logic [2:0] pick_sign(input logic       fund_sel,
                                            input logic [2:0] tot,
                                            input logic [2:0] fund);
      pick_sign = fund_sel ? fund : tot;
   endfunction

   // Widens a field to the bus with zeros above it
   function automatic logic [DATA_W-1:0] zext(input logic [FLAG_W-1:0] v);
      zext = {{(DATA_W-FLAG_W){1'b0}}, v};
   endfunction

   always_comb
   begin
      hf_vec = {half_bit.app, half_bit.fund_rea, half_bit.tot_rea,
                half_bit.fund_act, half_bit.tot_act};
      sel_sign = {power_sign_in.sum[2], power_sign_in.sum[1],
                  pick_sign(mode_reg[REA_SEL_BIT], power_sign_in.rea_tot,
                            power_sign_in.rea_fund),
                  power_sign_in.sum[0],
                  pick_sign(mode_reg[ACT_SEL_BIT], power_sign_in.act_tot,
                            power_sign_in.act_fund)};
   end

   mesf_change_det #(
      .W    (15)
   ) u_half_det (
      .clk  (clk),
      .rstn (rstn),
      .ce   (ce),
      .din  (hf_vec),
      .dq   (),
      .chg  (hf_chg)
   );

   // The delayed copy doubles as the readable sign register
   mesf_change_det #(
      .W    (SIGN_W)
   ) u_sign_det (
      .clk  (clk),
      .rstn (rstn),
      .ce   (ce),
      .din  (sel_sign),
      .dq   (power_sign_reg),
      .chg  (sign_chg)
   );

   // Watches the generator level, ahead of the disable gate
   mesf_change_det #(
      .W    (3)
   ) u_pulse_det (
      .clk  (clk),
      .rstn (rstn),
      .ce   (ce),
      .din  (pulse_out_level),
      .dq   (),
      .chg  (pulse_chg)
   );

   assign pulse_fall = pulse_chg & ~pulse_out_level;

   always_comb
   begin
      set_vec                   = '0;
      set_vec[TOT_ACT_HF_BIT]   = |hf_chg[2:0];
      set_vec[FUND_ACT_HF_BIT]  = |hf_chg[5:3];
      set_vec[TOT_REA_HF_BIT]   = |hf_chg[8:6];
      set_vec[FUND_REA_HF_BIT]  = |hf_chg[11:9];
      set_vec[APP_HF_BIT]       = |hf_chg[14:12];
      set_vec[LINE_CYC_BIT]     = ce & line_cycle_done;
      set_vec[ACT_FLIP_LSB+:3]  = sign_chg[ACT_SIGN_LSB+:3];
      set_vec[SUM_ONE_FLIP_BIT] = sign_chg[SUM_ONE_SIGN_BIT];
      set_vec[REA_FLIP_LSB+:3]  = sign_chg[REA_SIGN_LSB+:3];
      set_vec[SUM_TWO_FLIP_BIT] = sign_chg[SUM_TWO_SIGN_BIT];
      set_vec[SUM_THR_FLIP_BIT] = sign_chg[SUM_THR_SIGN_BIT];
      set_vec[PULSE_FLAG_LSB]   = pulse_fall[0];
      set_vec[PULSE_FLAG_LSB+1] = pulse_fall[1];
      set_vec[PULSE_FLAG_LSB+2] = pulse_fall[2];
      set_vec[COMPUTE_BIT]      = ce & compute_done;
   end

   always_comb
   begin
      status_next     = status_reg;
      mask_next       = mask_reg;
      mode_next       = mode_reg;
      pulse_mode_next = pulse_mode_reg;
      half_cyc_next   = half_cyc_reg;
      rdata_next      = rdata_reg;
      wr_clr          = '0;
      if (ce)
      begin
         rdata_next = '0;
         if (bus_req.wr && bus_req.addr == STATUS_ADDR)
         begin
            wr_clr = bus_req.wdata[FLAG_W-1:0];
         end
         // A new event beats a clear in the same cycle
         status_next = (status_reg & ~wr_clr) | set_vec;
         if (bus_req.wr)
         begin
            case (bus_req.addr)
               MASK_ADDR:       mask_next       = bus_req.wdata[FLAG_W-1:0];
               MODE_ADDR:       mode_next       = bus_req.wdata[MODE_W-1:0];
               PULSE_MODE_ADDR: pulse_mode_next = bus_req.wdata[PULSE_MODE_W-1:0];
               HALF_CYC_ADDR:   half_cyc_next   = bus_req.wdata[HALF_CYC_W-1:0];
               default:         mask_next       = mask_reg;
            endcase
         end
         if (bus_req.rd)
         begin
            case (bus_req.addr)
               STATUS_ADDR:     rdata_next = zext(status_reg);
               MASK_ADDR:       rdata_next = zext(mask_reg);
               MODE_ADDR:       rdata_next = {{(DATA_W-MODE_W){1'b0}}, mode_reg};
               PULSE_MODE_ADDR: rdata_next = {{(DATA_W-PULSE_MODE_W){1'b0}}, pulse_mode_reg};
               SIGN_ADDR:       rdata_next = {{(DATA_W-SIGN_W){1'b0}}, power_sign_reg};
               HALF_CYC_ADDR:   rdata_next = {{(DATA_W-HALF_CYC_W){1'b0}}, half_cyc_reg};
               default:         rdata_next = '0;
            endcase
         end
      end
      // Computed from next values so irq lines up with the status bits
      irq_next = |(status_next & mask_next);
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         status_reg     <= STATUS_RST;
         mask_reg       <= MASK_RST;
         mode_reg       <= MODE_RST;
         pulse_mode_reg <= PULSE_MODE_RST;
         half_cyc_reg   <= HALF_CYC_RST;
         rdata_reg      <= '0;
         irq_reg        <= 1'b0;
      end
      else
      begin
         status_reg     <= status_next;
         mask_reg       <= mask_next;
         mode_reg       <= mode_next;
         pulse_mode_reg <= pulse_mode_next;
         half_cyc_reg   <= half_cyc_next;
         rdata_reg      <= rdata_next;
         irq_reg        <= irq_next;
      end
   end

   assign rdata             = rdata_reg;
   assign irq               = irq_reg;
   assign measurement_mode  = mode_reg;
   assign pulse_output_mode = pulse_mode_reg;
   assign half_cycle_count  = half_cyc_reg;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   logic [FLAG_W-1:0] keep_vec;
   assign keep_vec = status_reg & ~wr_clr;

   a_total_act_half: assert property (ce && |hf_chg[2:0] |=> status_reg[TOT_ACT_HF_BIT])
      else $error("total active half flag not set");
   a_fund_act_half: assert property (
      ce && $changed(half_bit.fund_act) && $past(ce) && $past(rstn)
      |=> status_reg[FUND_ACT_HF_BIT])
      else $error("fundamental active half flag not set");
   a_total_rea_half: assert property (ce && |hf_chg[8:6] |=> status_reg[TOT_REA_HF_BIT])
      else $error("total reactive half flag not set");
   a_fund_rea_half: assert property (ce && |hf_chg[11:9] |=> status_reg[FUND_REA_HF_BIT])
      else $error("fundamental reactive half flag not set");
   a_apparent_half: assert property (ce && |hf_chg[14:12] |=> status_reg[APP_HF_BIT])
      else $error("apparent half flag not set");
   a_line_cycle_set: assert property (ce && line_cycle_done |=> status_reg[LINE_CYC_BIT])
      else $error("line cycle flag not set");
   a_act_sign_flip: assert property (
      ce && sign_chg[0] |=> status_reg[ACT_FLIP_LSB] && power_sign_reg[0] == $past(sel_sign[0]))
      else $error("phase A active sign flip not captured");
   a_sum_one_flip: assert property (
      ce && $past(ce) && $past(rstn)
      && power_sign_in.sum[0] != power_sign_reg[SUM_ONE_SIGN_BIT]
      |=> status_reg[SUM_ONE_FLIP_BIT]
      && power_sign_reg[SUM_ONE_SIGN_BIT] == $past(power_sign_in.sum[0]))
      else $error("sum one sign flip not captured");
   a_rea_sign_flip: assert property (
      ce && sign_chg[6] |=> status_reg[REA_FLIP_LSB+2] && power_sign_reg[6] == $past(sel_sign[6]))
      else $error("phase C reactive sign flip not captured");
   a_sum_two_flip: assert property (
      ce && sign_chg[SUM_TWO_SIGN_BIT] |=> status_reg[SUM_TWO_FLIP_BIT])
      else $error("sum two sign flip not flagged");
   a_sum_three_flip: assert property (
      ce && sign_chg[SUM_THR_SIGN_BIT] |=> status_reg[SUM_THR_FLIP_BIT])
      else $error("sum three sign flip not flagged");
   // A reset in the previous cycle leaves the detector unprimed, so no flag is owed
   a_pulse_one_fall: assert property (
      ce && $past(ce) && $past(rstn) && $fell(pulse_out_level[0])
      |=> status_reg[PULSE_FLAG_LSB])
      else $error("first pulse flag not set");
   a_pulse_two_fall: assert property (
      ce && pulse_fall[1] && pulse_mode_reg[DIS_TWO_BIT] |=> status_reg[PULSE_FLAG_LSB+1])
      else $error("second pulse flag not set while disabled");
   a_pulse_three_fall: assert property (
      ce && pulse_fall[2] |=> status_reg[PULSE_FLAG_LSB+2])
      else $error("third pulse flag not set");
   a_pulse_mode_write: assert property (
      ce && bus_req.wr && bus_req.addr == PULSE_MODE_ADDR
      |=> pulse_output_mode == $past(bus_req.wdata[PULSE_MODE_W-1:0]))
      else $error("pulse output mode not written");
   a_compute_done_set: assert property (ce && compute_done |=> status_reg[COMPUTE_BIT])
      else $error("compute done flag not set");
   a_reserved_zero: assert property (rdata[DATA_W-1:FLAG_W] == '0)
      else $error("reserved status bits not zero");
   a_flag_sticky: assert property (
      ce |=> (status_reg & $past(keep_vec)) == $past(keep_vec))
      else $error("status flag lost without clear");
   a_read_status: assert property (
      ce && bus_req.rd && bus_req.addr == STATUS_ADDR |=> rdata == zext($past(status_reg)))
      else $error("status read data wrong");
   a_irq_level: assert property (irq == |(status_reg & mask_reg))
      else $error("interrupt does not follow masked status");
   a_freeze_hold: assert property (!ce |=> $stable(status_reg) && $stable(rdata))
      else $error("state moved while clock enable low");

   c_flag_cleared: cover property (status_reg[COMPUTE_BIT] ##1 !status_reg[COMPUTE_BIT]);
   c_set_beats_clear: cover property (ce && |(set_vec & wr_clr));
   c_irq_raised: cover property ($rose(irq));
   c_sign_select_fund: cover property (mode_reg[ACT_SEL_BIT] && sign_chg[0]);

endmodule // mesf_status_bank
